// file: opg_ctrl.sv
`timescale 1ns/1ns
`include "opg_params.svh"
// Summary of operation
// [RQ1] Over-temperature latches protection and turns the companion off.
// [RQ2] Overpower counter runs while capacitor difference exceeds threshold.
// [RQ3] Counter past 50 or 200 ms enters latched or restart protection.
// [RQ4] Capacitor difference clamp maps to 150 or 200 percent by setting.
// [RQ5] A setting disables the overpower counter; overpower runs forever.
// [RQ6] Resistors are measured and settings latched before switching.
// [RQ7] Output-sense resistor selects burst rate 200 to 1600 Hz.
// [RQ8] First settings resistor below 10 kohm inhibits start-up.
// [RQ9] 46.4 kohm code gives 200 percent, infinite timer, no trip.
// [RQ10] Other codes give 125/175 percent level and 50/200 ms timer.
// [RQ11] Codes 53.6-82.5 restart after 1 s; 95.3-147 latch.
// [RQ12] End of power good is 45 ms or 190 ms per timer.
// [RQ13] Second resistor gives low-power level; open pin gives 62.5 percent.
// [RQ14] Burst entry level looked up from second resistor and rate.
// [RQ15] Settings pin becomes power good output and is not re-measured.
// [RQ16] After reading settings the power good pin is driven high.
// [RQ17] Entering operation drives the power good pin low.
// [RQ18] Boost low or counter at end count drives power good high.
// [RQ19] Power good withdraws 5 or 10 ms before overpower trip.
// [RQ20] Any protection stops switching at once and drives pin low.
// [RQ21] Latched protection holds until supply removal resets the device.
// [RQ22] Companion-disabling protections pull the boost-sense line low.
// [RQ23] Resistances quantize to nearest code, held until next power-up.
// [RQ24] Counter clears when difference drops below threshold early.
module opg_ctrl
  import opg_pkg::*;
#(
  parameter int unsigned OPP_SHORT_CYC = `OPG_OPP_SHORT_CYC,
  parameter int unsigned OPP_LONG_CYC  = `OPG_OPP_LONG_CYC,
  parameter int unsigned EPG_SHORT_CYC = `OPG_EPG_SHORT_CYC,
  parameter int unsigned EPG_LONG_CYC  = `OPG_EPG_LONG_CYC,
  parameter int unsigned RESTART_CYC   = `OPG_RESTART_CYC
)
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_reset,
  input  wire logic          i_meas_valid,
  input  wire logic [15:0]   i_set1_res,
  input  wire logic [15:0]   i_set2_res,
  input  wire logic          i_set2_open,
  input  wire logic [15:0]   i_out_res,
  input  wire logic          i_boost_start,
  input  opg_flags_t         i_flags,
  output logic               o_meas_req,
  output logic               o_switch_en,
  output logic               o_settings_pg_pin_o,
  output logic               o_settings_pg_pin_oe_n,
  output logic               o_boost_sense_pin_pull,
  output logic               o_cap_clamp_200,
  output logic               o_latched_prot,
  output opg_settings_t      o_settings
);
  typedef struct packed {
    opg_state_t    st;
    opg_settings_t set;
    logic [31:0]   cnt;
    logic          pg_high;
    logic          pfc_off;
  } opg_regs_t;

  opg_regs_t     r_r;
  opg_regs_t     r_nxt;
  opg_settings_t dec;
  logic [31:0]   opp_lim;
  logic [31:0]   epg_lim;
  logic          prot_hit;

  opg_decode u_dec (
    .i_set1_res  (i_set1_res),
    .i_set2_res  (i_set2_res),
    .i_set2_open (i_set2_open),
    .i_out_res   (i_out_res),
    .o_settings  (dec)
  );

  // Limits picked from the latched timer choice.
  always_comb begin
    opp_lim = r_r.set.timer_long ? 32'(OPP_LONG_CYC) : 32'(OPP_SHORT_CYC);
    epg_lim = r_r.set.timer_long ? 32'(EPG_LONG_CYC)
                                 : 32'(EPG_SHORT_CYC); // [RQ12] [RQ19]
    prot_hit = i_flags.over_volt | i_flags.over_curr | i_flags.under_volt
               | i_flags.over_temp;
  end

  // Sequencer: measure once, hold pin, run, protect.
  always_comb begin
    r_nxt = r_r;
    unique case (r_r.st)
      OPG_IDLE: begin
        r_nxt.st = OPG_MEASURE;
        r_nxt.pfc_off = 1'b1;
      end
      OPG_MEASURE: begin
        if (i_meas_valid) begin
          r_nxt.set = dec; // [RQ6] [RQ23]
          r_nxt.st = dec.no_start ? OPG_INHIBIT : OPG_READY; // [RQ8]
          r_nxt.pg_high = 1'b1; // [RQ16]
          r_nxt.pfc_off = dec.no_start;
        end
      end
      OPG_READY: begin
        if (prot_hit) begin
          r_nxt.st = OPG_LATCH;
          r_nxt.pg_high = 1'b0; // [RQ20]
          r_nxt.pfc_off = 1'b1;
        end else if (i_boost_start) begin
          r_nxt.st = OPG_RUN;
          r_nxt.pg_high = 1'b0; // [RQ17]
          r_nxt.cnt = '0;
        end
      end
      OPG_RUN: begin
        // Counter clears to zero when below threshold or disabled.
        if (i_flags.opp_exceed && !r_r.set.opp_infinite) begin // [RQ5] [RQ9]
          r_nxt.cnt = r_r.cnt + 32'h0000_0001; // [RQ2]
        end else begin
          r_nxt.cnt = '0; // [RQ24]
        end
        if (i_flags.boost_low || r_r.cnt >= epg_lim) begin
          r_nxt.pg_high = 1'b1; // [RQ18]
        end
        if (prot_hit) begin
          r_nxt.st = OPG_LATCH; // [RQ1] [RQ20]
          r_nxt.pg_high = 1'b0;
          r_nxt.pfc_off = 1'b1; // [RQ22]
        end else if (r_r.cnt >= opp_lim && !r_r.set.opp_infinite) begin
          r_nxt.st = r_r.set.latched ? OPG_LATCH : OPG_RESTART; // [RQ3] [RQ11]
          r_nxt.pg_high = 1'b0;
          r_nxt.pfc_off = 1'b1;
          r_nxt.cnt = '0;
        end
      end
      OPG_RESTART: begin
        // Safe restart waits 1 s then returns to the ready state.
        r_nxt.cnt = r_r.cnt + 32'h0000_0001;
        if (i_flags.over_temp) begin
          r_nxt.st = OPG_LATCH; // [RQ1]
        end else if (r_r.cnt >= 32'(RESTART_CYC) - 32'h0000_0001) begin
          r_nxt.st = OPG_READY; // [RQ11]
          r_nxt.pg_high = 1'b1;
          r_nxt.pfc_off = 1'b0;
          r_nxt.cnt = '0;
        end
      end
      OPG_LATCH: begin
        r_nxt.pfc_off = 1'b1; // [RQ21] [RQ22]
      end
      OPG_INHIBIT: begin
        r_nxt.pfc_off = 1'b1;
      end
    endcase
  end

  // All state in one register; only supply loss (reset) clears a latch.
  always_ff @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      r_r <= '0; // [RQ21]
    end else begin
      r_r <= r_nxt;
    end
  end

  // Outputs; pin measurement only requested before settings exist.
  always_comb begin
    o_meas_req = (r_r.st == OPG_MEASURE); // [RQ15]
    o_switch_en = (r_r.st == OPG_RUN) && !prot_hit; // [RQ20]
    o_settings_pg_pin_o = r_r.pg_high;
    o_settings_pg_pin_oe_n = (r_r.st == OPG_MEASURE) || (r_r.st == OPG_IDLE);
    o_boost_sense_pin_pull = r_r.pfc_off; // [RQ22]
    o_cap_clamp_200 = r_r.set.cap_200; // [RQ4]
    o_latched_prot = (r_r.st == OPG_LATCH);
    o_settings = r_r.set;
  end
endmodule : opg_ctrl

// file: opg_params.svh
`ifndef OPG_PARAMS_SVH
`define OPG_PARAMS_SVH
// Clock rate in kHz, so that millisecond figures turn into cycle counts.
`define OPG_CLK_KHZ          250000
// Overpower timer and end-of-power-good figures in milliseconds.
`define OPG_OPP_SHORT_MS     50
`define OPG_OPP_LONG_MS      200
`define OPG_EPG_SHORT_MS     45
`define OPG_EPG_LONG_MS      190
`define OPG_RESTART_MS       1000
// Cycle counts derived from the figures above.
`define OPG_OPP_SHORT_CYC    (`OPG_OPP_SHORT_MS * `OPG_CLK_KHZ)
`define OPG_OPP_LONG_CYC     (`OPG_OPP_LONG_MS * `OPG_CLK_KHZ)
`define OPG_EPG_SHORT_CYC    (`OPG_EPG_SHORT_MS * `OPG_CLK_KHZ)
`define OPG_EPG_LONG_CYC     (`OPG_EPG_LONG_MS * `OPG_CLK_KHZ)
`define OPG_RESTART_CYC      (`OPG_RESTART_MS * `OPG_CLK_KHZ)
// Resistor thresholds in units of 100 ohm, midway between table codes.
`define OPG_SET1_SHORT       16'h0064
`define OPG_SET1_B0          16'h01F2
`define OPG_SET1_B1          16'h0242
`define OPG_SET1_B2          16'h029D
`define OPG_SET1_B3          16'h0305
`define OPG_SET1_B4          16'h037F
`define OPG_SET1_B5          16'h040B
`define OPG_SET1_B6          16'h04A4
`define OPG_SET1_B7          16'h0551
`define OPG_SET2_B0          16'h0027
`define OPG_SET2_B1          16'h006C
`define OPG_SET2_B2          16'h00D2
`define OPG_SET2_B3          16'h0172
`define OPG_SET2_B4          16'h0276
`define OPG_SET2_B5          16'h0505
`define OPG_SET2_B6          16'h0BB8
`define OPG_OUT_B0           16'h0053
`define OPG_OUT_B1           16'h007D
`define OPG_OUT_B2           16'h00B9
// Burst entry level in half percent units, indexed [set2 code][rate code].
`define OPG_BURST_TABLE { \
  8'h12, 8'h12, 8'h12, 8'h12, 8'h18, 8'h18, 8'h18, 8'h18, \
  8'h12, 8'h12, 8'h12, 8'h14, 8'h18, 8'h18, 8'h18, 8'h1A, \
  8'h12, 8'h14, 8'h16, 8'h18, 8'h18, 8'h1A, 8'h1E, 8'h22, \
  8'h12, 8'h14, 8'h18, 8'h1C, 8'h18, 8'h1E, 8'h23, 8'h28 }
`endif

// file: opg_pkg.sv
package opg_pkg;
  // Decoded settings shared between the decoder and the main controller.
  typedef struct packed {
    logic       no_start;     // Settings pin shorted.
    logic       opp_infinite; // Overpower counter disabled.
    logic       cap_200;      // Power capability 200 % (else 150 %).
    logic       lvl_175;      // Overpower start level 175 % (else 125 %).
    logic       timer_long;   // 200 ms timer (else 50 ms).
    logic       latched;      // Latched protection (else 1 s restart).
    logic [1:0] burst_rate;   // 0:200 Hz 1:400 Hz 2:800 Hz 3:1600 Hz.
    logic [1:0] lpm_level;    // 0:25 1:37.5 2:50 3:62.5 percent.
    logic [7:0] burst_level;  // Burst entry level, half percent units.
  } opg_settings_t;

  typedef enum logic [2:0] {
    OPG_IDLE, OPG_MEASURE, OPG_READY, OPG_RUN, OPG_RESTART, OPG_LATCH,
    OPG_INHIBIT
  } opg_state_t;

  // Protection and sense flags coming from the converter core.
  typedef struct packed {
    logic over_temp;
    logic over_volt;
    logic over_curr;
    logic under_volt;
    logic boost_low;
    logic opp_exceed;
  } opg_flags_t;
endpackage : opg_pkg

// file: opg_decode.sv
`timescale 1ns/1ns
`include "opg_params.svh"
// Quantizes the three measured resistances into the settings word.
module opg_decode
  import opg_pkg::*;
(
  input  wire logic [15:0]   i_set1_res,
  input  wire logic [15:0]   i_set2_res,
  input  wire logic          i_set2_open,
  input  wire logic [15:0]   i_out_res,
  output opg_settings_t      o_settings
);
  localparam logic [255:0] BURST_TBL = `OPG_BURST_TABLE;

  // Index of the first band the value falls under, nearest code wins.
  function automatic logic [2:0] band8(input logic [15:0] v,
                                       input logic [111:0] b);
    logic [2:0] k;
    k = 3'h7;
    for (int i = 6; i >= 0; i--) begin
      if (v < b[i*16 +: 16]) begin
        k = 3'(i);
      end
    end
    return k;
  endfunction : band8

  logic [2:0] s1;
  logic [2:0] s2;
  logic [2:0] so;
  logic [3:0] s1p;
  logic [4:0] idx;

  // Decode of the three resistors; every field is a pure function of them.
  always_comb begin
    s1 = band8(i_set1_res, {`OPG_SET1_B7, `OPG_SET1_B6, `OPG_SET1_B5,
               `OPG_SET1_B4, `OPG_SET1_B3, `OPG_SET1_B2, `OPG_SET1_B1});
    s1p = (i_set1_res < `OPG_SET1_B0) ? 4'h0 : {1'b0, s1} + 4'h1;
    s2 = i_set2_open ? 3'h7 : band8(i_set2_res, {`OPG_SET2_B6,
         `OPG_SET2_B5, `OPG_SET2_B4, `OPG_SET2_B3, `OPG_SET2_B2,
         `OPG_SET2_B1, `OPG_SET2_B0});
    so = band8(i_out_res, {16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF,
               `OPG_OUT_B2, `OPG_OUT_B1, `OPG_OUT_B0});
    o_settings = '0;
    o_settings.no_start = (i_set1_res < `OPG_SET1_SHORT); // [RQ8]
    o_settings.opp_infinite = (s1p == 4'h0); // [RQ9]
    // Band s1 counts the timed codes upward: odd bands take the short
    // timer, bands 2-3 and 6-7 the low level, bands 4-7 the latch.
    o_settings.cap_200 = (s1p == 4'h0) | ~s1[1]; // [RQ4]
    o_settings.lvl_175 = ~s1[1]; // [RQ10]
    o_settings.timer_long = ~s1[0]; // [RQ10]
    o_settings.latched = s1[2]; // [RQ11]
    // Fast rates are the small resistors.
    o_settings.burst_rate = 2'h3 - so[1:0]; // [RQ7]
    o_settings.lpm_level = s2[2:1]; // [RQ13]
    idx = {s2, o_settings.burst_rate};
    o_settings.burst_level =
      BURST_TBL[(8'h1F - {3'h0, idx}) * 8 +: 8]; // [RQ14]
  end
endmodule : opg_decode

// file: opg_pfc_model.sv
`timescale 1ns/1ns
// Companion controller: the boost level recovers a while after release.
module opg_pfc_model #(
  parameter int DLY = 6
) (
  input  wire logic i_sys_clk,
  input  wire logic i_pull,
  output logic      o_boost_start = 1'b0
);
  int cnt = 0;
  // A pulled line restarts the wait, as the divider must settle again.
  always @(posedge i_sys_clk) begin
    cnt <= i_pull ? 0 : (cnt < DLY ? cnt + 1 : cnt);
    o_boost_start <= !i_pull && cnt == DLY;
  end
endmodule : opg_pfc_model

// file: opg_ctrl_chk.sv
`timescale 1ns/1ns
// Pin-level checks; all of them live in the single system clock domain.
module opg_ctrl_chk
  import opg_pkg::*;
(
  input wire logic    i_sys_clk,
  input wire logic    i_reset,
  input wire logic    i_meas_valid,
  input opg_flags_t   i_flags,
  input wire logic    o_meas_req,
  input wire logic    o_switch_en,
  input wire logic    o_settings_pg_pin_o,
  input wire logic    o_settings_pg_pin_oe_n,
  input wire logic    o_boost_sense_pin_pull,
  input wire logic    o_cap_clamp_200,
  input wire logic    o_latched_prot,
  input opg_settings_t o_settings
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Faults, latching, measurement and power-good timing.
  prot_stop_a: assert property (
    |i_flags[5:2] |-> !o_switch_en)
    else $error("switching while a fault flag is set");
  otp_latch_a: assert property (
    i_flags.over_temp && !o_settings_pg_pin_oe_n && !o_settings.no_start
    |=> o_latched_prot && o_boost_sense_pin_pull)
    else $error("over temperature did not latch");
  latch_hold_a: assert property (
    o_latched_prot |=> o_latched_prot)
    else $error("latched protection released");
  latch_quiet_a: assert property (
    o_latched_prot |-> !o_switch_en && !o_settings_pg_pin_o
    && o_boost_sense_pin_pull)
    else $error("latched state outputs wrong");
  meas_quiet_a: assert property (
    o_meas_req |-> !o_switch_en && o_settings_pg_pin_oe_n)
    else $error("pin driven during measure");
  settle_pin_a: assert property (
    o_meas_req && i_meas_valid |=> !o_meas_req
    && (o_settings.no_start || o_settings_pg_pin_o))
    else $error("pin not high after settings read");
  hold_set_a: assert property (
    !o_meas_req && !$past(o_meas_req) |-> $stable(o_settings))
    else $error("settings changed after read");
  // Capability follows the timer start level; the untimed code is 200 %.
  clamp_a: assert property (
    !o_meas_req |-> o_cap_clamp_200
    == (o_settings.opp_infinite || o_settings.lvl_175))
    else $error("clamp mismatch");
  boost_pg_a: assert property (
    o_switch_en && i_flags.boost_low |=> o_settings_pg_pin_o)
    else $error("boost low kept power good");
  lead_short_a: assert property (
    $rose(o_settings_pg_pin_o) && $past(o_switch_en)
    && i_flags.opp_exceed && !i_flags.boost_low && !o_settings.timer_long
    |-> o_switch_en [*4] ##[1:3] !o_switch_en)
    else $error("short power good lead wrong");
  lead_long_a: assert property (
    $rose(o_settings_pg_pin_o) && $past(o_switch_en)
    && i_flags.opp_exceed && !i_flags.boost_low && o_settings.timer_long
    |-> o_switch_en [*8] ##[1:3] !o_switch_en)
    else $error("long power good lead wrong");
endmodule : opg_ctrl_chk
bind opg_ctrl opg_ctrl_chk opg_ctrl_chk_i (.i_sys_clk, .i_reset,
  .i_meas_valid, .i_flags, .o_meas_req, .o_switch_en, .o_settings_pg_pin_o,
  .o_settings_pg_pin_oe_n, .o_boost_sense_pin_pull, .o_cap_clamp_200,
  .o_latched_prot, .o_settings);

// file: opg_bench.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module opg_bench;
  import opg_pkg::*;
  logic          i_sys_clk = 1'b0;
  logic          i_reset = 1'b1;
  logic          i_meas_valid = 1'b0;
  logic          i_set2_open = 1'b0;
  logic [15:0]   i_set1_res = 16'h0000;
  logic [15:0]   i_set2_res = 16'h0000;
  logic [15:0]   i_out_res = 16'h0000;
  opg_flags_t    i_flags = '0;
  logic          i_boost_start, o_meas_req, o_switch_en, o_latched_prot;
  logic          o_settings_pg_pin_o, o_settings_pg_pin_oe_n;
  logic          o_boost_sense_pin_pull, o_cap_clamp_200;
  opg_settings_t o_settings;
  int            n_mismatch = 0;
  int            check_count = 0;
  // Codes in 100 ohm units; e4 is {cap, level, long timer, latched}.
  logic [15:0]   s1 [8] = '{16'h0218, 16'h026B, 16'h02CB, 16'h0339,
                            16'h03B9, 16'h044C, 16'h04F6, 16'h05BE};
  logic [3:0]    e4 [8] = '{4'hE, 4'hC, 4'h2, 4'h0, 4'hF, 4'hD, 4'h3, 4'h1};
  logic [15:0]   s2 [8] = '{16'h000A, 16'h0044, 16'h0096, 16'h010E,
                            16'h01D6, 16'h0334, 16'h0708, 16'h0000};
  logic [15:0]   ro [4] = '{16'h00DC, 16'h0096, 16'h0064, 16'h0044};
  logic [7:0]    bl [8] = '{8'h12, 8'h18, 8'h12, 8'h1A,
                            8'h12, 8'h1A, 8'h18, 8'h28};
  always #2 i_sys_clk = ~i_sys_clk;
  // Timers shortened so that a trip takes 50 or 200 cycles, not millions.
  opg_ctrl #(.OPP_SHORT_CYC(50), .OPP_LONG_CYC(200), .EPG_SHORT_CYC(45),
    .EPG_LONG_CYC(190), .RESTART_CYC(100)) opg_ctrl_i (.i_sys_clk,
    .i_reset, .i_meas_valid, .i_set1_res, .i_set2_res, .i_set2_open,
    .i_out_res, .i_boost_start, .i_flags, .o_meas_req, .o_switch_en,
    .o_settings_pg_pin_o, .o_settings_pg_pin_oe_n, .o_boost_sense_pin_pull,
    .o_cap_clamp_200, .o_latched_prot, .o_settings);
  opg_pfc_model opg_pfc_model_i (.i_sys_clk,
    .i_pull(o_boost_sense_pin_pull), .o_boost_start(i_boost_start));
  // Every task except stop_test starts on an edge, so inputs never move off the edge.
  task automatic boot(input int k, input logic [15:0] r1);
    @(posedge i_sys_clk);
    i_reset <= 1'b1;
    i_flags <= '0;
    i_set1_res <= r1;
    i_set2_res <= s2[k];
    i_set2_open <= (k == 7);
    i_out_res <= ro[k % 4];
    repeat (10) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_meas_valid <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    i_meas_valid <= 1'b0;
    #1;
    if (r1 > 16'h0064) `CHK(o_settings_pg_pin_o, 1'b1)
  endtask : boot
  task automatic run;
    @(posedge i_sys_clk);
    for (int t = 0; t < 40 && o_switch_en !== 1'b1; t++)
      @(posedge i_sys_clk);
    #1;
    `CHK({o_switch_en, o_settings_pg_pin_o}, 2'b10)
  endtask : run
  task automatic hold(input int n);
    @(posedge i_sys_clk);
    i_flags.opp_exceed <= 1'b1;
    repeat (n) @(posedge i_sys_clk);
    i_flags.opp_exceed <= 1'b0;
    @(posedge i_sys_clk);
    #1;
  endtask : hold
  task automatic trip(input int epg, input int opp, input logic lat);
    int t;
    @(posedge i_sys_clk);
    i_flags.opp_exceed <= 1'b1;
    for (t = 0; t < 400 && o_switch_en; t++) begin
      @(posedge i_sys_clk);
      #1;
      if (t == epg - 3) `CHK(o_settings_pg_pin_o, 1'b0)
      if (t == opp - 3) `CHK(o_settings_pg_pin_o, 1'b1)
    end
    `CHK(t >= opp - 1 && t <= opp + 3, 1'b1)
    `CHK({o_settings_pg_pin_o, o_boost_sense_pin_pull}, 2'b01)
    `CHK(o_latched_prot, lat)
    @(posedge i_sys_clk);
    i_flags.opp_exceed <= 1'b0;
    repeat (90) @(posedge i_sys_clk);
    #1;
    `CHK(o_switch_en, 1'b0)
    for (t = 0; t < 60 && !o_switch_en; t++) @(posedge i_sys_clk);
    #1;
    `CHK(o_switch_en, !lat)
  endtask : trip
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test
  // The tests need some 2000 cycles; twelve times that means a hang.
  initial begin
    #100000;
    n_mismatch++;
    stop_test();
  end
  initial begin
    for (int k = 0; k < 8; k++) begin
      boot(k, s1[k]);
      `CHK(o_settings[17:12], {2'b00, e4[k]})
      `CHK(o_settings.burst_rate, 2'(k % 4))
      `CHK(o_settings.lpm_level, 2'(k / 2))
      `CHK(o_settings.burst_level, bl[k])
      `CHK(o_cap_clamp_200, e4[k][3])
      run();
      if (k == 0) begin
        hold(150);
        hold(150);
        `CHK({o_switch_en, o_settings_pg_pin_o}, 2'b10)
      end
      if (k == 0 || k == 3 || k == 5 || k == 6)
        trip(e4[k][1] ? 190 : 45, e4[k][1] ? 200 : 50, e4[k][0]);
      $display("decode test %0d done", k);
    end
    boot(0, 16'h01D0);
    `CHK({o_settings.opp_infinite, o_settings.cap_200}, 2'b11)
    run();
    hold(300);
    `CHK({o_switch_en, o_settings_pg_pin_o}, 2'b10)
    @(posedge i_sys_clk);
    i_flags.boost_low <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK(o_settings_pg_pin_o, 1'b1)
    boot(0, 16'h0032);
    repeat (30) @(posedge i_sys_clk);
    #1;
    `CHK({o_settings.no_start, o_switch_en}, 2'b10)
    $display("infinite and short tests done");
    for (int j = 0; j < 4; j++) begin
      boot(3, s1[3]);
      run();
      @(posedge i_sys_clk);
      i_flags <= opg_flags_t'(6'h20 >> j);
      #1;
      `CHK(o_switch_en, 1'b0)
      repeat (3) @(posedge i_sys_clk);
      #1;
      `CHK({o_settings_pg_pin_o, o_boost_sense_pin_pull}, 2'b01)
      `CHK(o_latched_prot, 1'b1)
    end
    $display("protection tests done");
    stop_test();
  end
endmodule : opg_bench
